// File: region_addr_cfg.svh
// Offsets, field positions, reset values and counts for operand addressing
// Function
// - Support direct addressing plus origin, row and element indexed indirect.
// - Direct mode takes every region field from the instruction word.
// - Origin-indexed mode takes only the origin from one address register.
// - Row-indexed mode takes each row origin from successive address registers.
// - Address register bits 15:5 give register index, 4:0 byte offset.
// - Row step 0xF selects row or element indexed operation.
// - Width 1 indirect uses one address register per channel.
// - One access-mode bit picks quad or element aligned handling.
// - Quad mode origins sit on 16-byte boundaries, four elements per row.
// - Quad mode applies swizzle and write mask repeated every four channels.
// - Element mode allows element-size alignment and full 2D regions.
// - Element mode does no swizzle and no destination masking.
// - Each instruction runs in word, doubleword, float or double type.
// - Unsigned integer sources become signed; integer execution is signed.
// - Byte sources promote to word or wider; never execute bytes.
// - Mixed integer widths execute at the widest source width.
// - Keep extra precision so unsigned to signed conversion loses nothing.
// - Element step 0 width 8 replicates the row origin element.
// - A source region may straddle two consecutive registers.
// - Byte address is register index times 32 plus subregister offset in element units.
// - Element step spaces row elements, row step spaces rows, element units.
`ifndef REGION_ADDR_CFG_SVH
`define REGION_ADDR_CFG_SVH
`define CFG_CTRL_OFF     12'h000
`define CFG_STAT_OFF     12'h004
`define CFG_AREG_PAGE    6'h01
`define CFG_CTRL_RST     1'h0
`define CFG_AREG_NUM     16
`define CFG_AREG_RST     16'h0000
`define CFG_AREG_IDX_HI  15
`define CFG_AREG_IDX_LO  5
`define CFG_SUB_W        5
`define CFG_ROW_IND      6'h0F
`define CFG_QUAD_WIDTH   6'h04
`define CFG_QUAD_MASK    16'hFFF0
`endif

// File: region_addr_pkg.sv
// Types shared by the operand addressing block
package region_addr_pkg;
  typedef enum logic [3:0] {T_UB, T_B, T_UW, T_W, T_UD, T_D, T_F, T_VF,
                            T_DF} src_type_t;
  typedef enum logic [1:0] {X_W, X_D, X_F, X_DF} exec_type_t;
  typedef enum logic [1:0] {M_DIRECT, M_ORIGIN, M_ROW, M_ELEM} addr_form_t;
  typedef struct packed {
    logic        valid;
    logic        quad;
    logic        indirect;
    logic [10:0] register_index;
    logic [4:0]  subregister_offset;
    logic [5:0]  row_step;
    logic [5:0]  width;
    logic [5:0]  element_step;
    src_type_t   first_source_type;
    src_type_t   second_source_type;
    logic [5:0]  channel_count;
    logic [3:0]  areg_start;
    logic [7:0]  swizzle;
    logic [3:0]  write_mask;
  } region_req_t;
  typedef struct packed {
    logic         valid;
    logic [10:0]  index;
    logic [255:0] data;
    logic [31:0]  byte_en;
  } wb_req_t;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic       quad;
    logic       lane_en;
    logic [5:0] ch;
    logic [4:0] off;
    src_type_t  t;
    exec_type_t x;
  } elem_meta_t;
  typedef struct packed {
    logic        valid;
    logic        last;
    logic        lane_en;
    logic [5:0]  ch;
    exec_type_t  exec;
    logic [63:0] value;
  } elem_out_t;
endpackage : region_addr_pkg

// File: region_register_array.sv
// General register array of 256-bit words, registered read port
`timescale 1ns/1ps
module region_register_array #(
  parameter int unsigned IDX_W = 7
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               rd_en,
  input  wire logic [IDX_W-1:0]   rd_idx,
  output logic      [255:0]       rd_data,
  input  wire logic               wr_en,
  input  wire logic [IDX_W-1:0]   wr_idx,
  input  wire logic [255:0]       wr_data,
  input  wire logic [31:0]        wr_be
);
  logic [255:0] mem [2**IDX_W];
  logic [255:0] rd_data_ff;

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      for (int b = 0; b < 32; b++)
        if (wr_be[b])
          mem[wr_idx][b*8 +: 8] <= wr_data[b*8 +: 8];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_ff <= 256'h0;
    else if (rd_en)
      rd_data_ff <= mem[rd_idx];
  end

  assign rd_data = rd_data_ff;
endmodule : region_register_array

// File: region_operand_addressing.sv
// Operand region address generation with APB control and address registers
`timescale 1ns/1ps
`include "region_addr_cfg.svh"
module region_operand_addressing #(
  parameter int unsigned REG_IDX_W = 7
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire region_addr_pkg::region_req_t req,
  output logic                             req_ready,
  input  wire region_addr_pkg::wb_req_t    wb,
  output region_addr_pkg::elem_out_t       elem
);
  typedef enum logic {S_IDLE, S_RUN} state_t;

  state_t                       state_ff, nxt_state;
  logic [5:0]                   x_ff, nxt_x, y_ff, nxt_y, ch_ff, nxt_ch;
  region_addr_pkg::region_req_t req_ff, nxt_req;
  region_addr_pkg::addr_form_t  form_ff, nxt_form;
  region_addr_pkg::exec_type_t  exec_ff, nxt_exec;
  logic [3:0]                   es_ff, nxt_es;
  logic                         ready_ff, nxt_ready;
  logic                         ctrl_en_ff, nxt_ctrl_en;
  logic [15:0]                  areg_ff [`CFG_AREG_NUM];
  logic [15:0]                  nxt_areg [`CFG_AREG_NUM];
  logic [15:0]                  done_ff, nxt_done;
  logic [31:0]                  prdata_ff, nxt_prdata;
  logic                         pready_ff, nxt_pready;
  logic                         pslverr_ff, nxt_pslverr;
  region_addr_pkg::elem_meta_t  s0_ff, nxt_s0, s1_ff, nxt_s1;
  region_addr_pkg::elem_out_t   out_ff, nxt_out;
  logic [15:0]                  addr_ff, nxt_addr;
  logic [255:0]                 rd_data;
  logic [255:0]                 rd_shift;
  logic                         accept;
  logic [5:0]                   row_w;
  logic [3:0]                   row_idx, el_idx;
  logic [15:0]                  origin_d, org, row_base, col, addr_c;
  logic [15:0]                  elem_ptr;
  logic [1:0]                   swz;
  logic                         setup, wr_fire, areg_hit, bad;

  function automatic logic [3:0] elem_bytes(region_addr_pkg::src_type_t t);
    case (t)
      region_addr_pkg::T_UB, region_addr_pkg::T_B: return 4'h1;
      region_addr_pkg::T_UW, region_addr_pkg::T_W: return 4'h2;
      region_addr_pkg::T_DF:                       return 4'h8;
      default:                                     return 4'h4;
    endcase
  endfunction : elem_bytes

  // Issuer never mixes float with integer, so any float wins outright
  function automatic region_addr_pkg::exec_type_t exec_of(
    region_addr_pkg::src_type_t a, region_addr_pkg::src_type_t b);
    if (a == region_addr_pkg::T_DF || b == region_addr_pkg::T_DF)
      return region_addr_pkg::X_DF;
    if (a inside {region_addr_pkg::T_F, region_addr_pkg::T_VF} ||
        b inside {region_addr_pkg::T_F, region_addr_pkg::T_VF})
      return region_addr_pkg::X_F;
    if (a inside {region_addr_pkg::T_UD, region_addr_pkg::T_D} ||
        b inside {region_addr_pkg::T_UD, region_addr_pkg::T_D})
      return region_addr_pkg::X_D;
    return region_addr_pkg::X_W;
  endfunction : exec_of

  // 64-bit carrier leaves headroom so unsigned values keep their magnitude
  function automatic logic [63:0] widen(logic [63:0] r,
                                        region_addr_pkg::src_type_t t);
    case (t)
      region_addr_pkg::T_UB: return {56'h0, r[7:0]};
      region_addr_pkg::T_B:  return {{56{r[7]}}, r[7:0]};
      region_addr_pkg::T_UW: return {48'h0, r[15:0]};
      region_addr_pkg::T_W:  return {{48{r[15]}}, r[15:0]};
      region_addr_pkg::T_UD: return {32'h0, r[31:0]};
      region_addr_pkg::T_D:  return {{32{r[31]}}, r[31:0]};
      region_addr_pkg::T_DF: return r;
      default:               return {32'h0, r[31:0]};
    endcase
  endfunction : widen

  function automatic region_addr_pkg::addr_form_t form_of(
    region_addr_pkg::region_req_t q);
    if (!q.indirect)
      return region_addr_pkg::M_DIRECT;
    if (q.row_step != `CFG_ROW_IND)
      return region_addr_pkg::M_ORIGIN;
    if (q.width == 6'h01)
      return region_addr_pkg::M_ELEM;
    return region_addr_pkg::M_ROW;
  endfunction : form_of

  // Sequencer: one channel per cycle
  assign accept = req.valid && ready_ff;
  assign row_w  = req_ff.quad ? `CFG_QUAD_WIDTH : req_ff.width;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_x     = x_ff;
    nxt_y     = y_ff;
    nxt_ch    = ch_ff;
    nxt_req   = req_ff;
    nxt_form  = form_ff;
    nxt_exec  = exec_ff;
    nxt_es    = es_ff;
    case (state_ff)
      S_IDLE:
      begin
        if (accept)
        begin
          nxt_state = S_RUN;
          nxt_req   = req;
          nxt_form  = form_of(req);
          nxt_es    = elem_bytes(req.first_source_type);
          nxt_exec  = exec_of(req.first_source_type,
                              req.second_source_type);
          nxt_x     = 6'h00;
          nxt_y     = 6'h00;
          nxt_ch    = 6'h00;
        end
      end
      S_RUN:
      begin
        nxt_ch = ch_ff + 6'h01;
        if (x_ff == row_w - 6'h01)
        begin
          nxt_x = 6'h00;
          nxt_y = y_ff + 6'h01;
        end
        else
          nxt_x = x_ff + 6'h01;
        if (ch_ff == req_ff.channel_count - 6'h01)
          nxt_state = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
    nxt_ready = (nxt_state == S_IDLE) && ctrl_en_ff;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= S_IDLE;
      x_ff     <= 6'h00;
      y_ff     <= 6'h00;
      ch_ff    <= 6'h00;
      req_ff   <= '0;
      form_ff  <= region_addr_pkg::M_DIRECT;
      exec_ff  <= region_addr_pkg::X_W;
      es_ff    <= 4'h1;
      ready_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      x_ff     <= nxt_x;
      y_ff     <= nxt_y;
      ch_ff    <= nxt_ch;
      req_ff   <= nxt_req;
      form_ff  <= nxt_form;
      exec_ff  <= nxt_exec;
      es_ff    <= nxt_es;
      ready_ff <= nxt_ready;
    end
  end

  // Address of the current channel
  assign row_idx  = 4'(req_ff.areg_start + y_ff[3:0]);
  assign el_idx   = 4'(req_ff.areg_start + ch_ff[3:0]);
  assign elem_ptr = areg_ff[el_idx];
  assign origin_d = {req_ff.register_index, 5'h00} +
                    16'(req_ff.subregister_offset * es_ff);
  assign org      = (form_ff == region_addr_pkg::M_DIRECT) ? origin_d
                    : areg_ff[req_ff.areg_start];
  assign swz      = req_ff.swizzle[{ch_ff[1:0], 1'b0} +: 2];

  always_comb
  begin
    case (form_ff)
      region_addr_pkg::M_ROW:  row_base = areg_ff[row_idx];
      region_addr_pkg::M_ELEM: row_base = elem_ptr;
      default: row_base = org + 16'(y_ff * req_ff.row_step * es_ff);
    endcase
    if (req_ff.quad)
    begin
      row_base = row_base & `CFG_QUAD_MASK;
      col      = 16'(swz * es_ff);
    end
    else
      col = 16'(x_ff * req_ff.element_step * es_ff);
    // Each element carries its own register index, so straddling is free
    addr_c = row_base + col;
  end

  // Pipeline: address, array read, element extract
  assign rd_shift = rd_data >> {s1_ff.off, 3'b000};

  always_comb
  begin
    nxt_s0.valid   = (state_ff == S_RUN);
    nxt_s0.last    = (ch_ff == req_ff.channel_count - 6'h01);
    nxt_s0.quad    = req_ff.quad;
    nxt_s0.lane_en = req_ff.quad ? req_ff.write_mask[ch_ff[1:0]]
                                 : 1'b1;
    nxt_s0.ch      = ch_ff;
    nxt_s0.off     = addr_c[4:0];
    nxt_s0.t       = req_ff.first_source_type;
    nxt_s0.x       = exec_ff;
    nxt_addr       = addr_c;
    nxt_s1         = s0_ff;
    nxt_out.valid   = s1_ff.valid;
    nxt_out.last    = s1_ff.last;
    nxt_out.lane_en = s1_ff.lane_en;
    nxt_out.ch      = s1_ff.ch;
    nxt_out.exec    = s1_ff.x;
    nxt_out.value   = widen(rd_shift[63:0], s1_ff.t);
    nxt_done        = done_ff + {15'h0000, s0_ff.valid & s0_ff.last};
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s0_ff   <= '0;
      s1_ff   <= '0;
      out_ff  <= '0;
      addr_ff <= 16'h0000;
      done_ff <= 16'h0000;
    end
    else
    begin
      s0_ff   <= nxt_s0;
      s1_ff   <= nxt_s1;
      out_ff  <= nxt_out;
      addr_ff <= nxt_addr;
      done_ff <= nxt_done;
    end
  end

  // Destination writes land in one register per beat
  region_register_array #(
    .IDX_W (REG_IDX_W)
  ) region_register_array_inst (
    .clock   (clock),
    .rst_n   (rst_n),
    .rd_en   (s0_ff.valid),
    .rd_idx  (addr_ff[`CFG_SUB_W +: REG_IDX_W]),
    .rd_data (rd_data),
    .wr_en   (wb.valid),
    .wr_idx  (wb.index[REG_IDX_W-1:0]),
    .wr_data (wb.data),
    .wr_be   (wb.byte_en)
  );

  // APB slave: one wait-free access phase
  assign setup    = psel && !penable;
  assign wr_fire  = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign areg_hit = (paddr[11:6] == `CFG_AREG_PAGE);
  assign bad      = (paddr[1:0] != 2'h0) ||
                    !(areg_hit || paddr == `CFG_CTRL_OFF ||
                      paddr == `CFG_STAT_OFF);

  for (genvar i = 0; i < `CFG_AREG_NUM; i++)
  begin : g_areg
    assign nxt_areg[i] = (wr_fire && areg_hit && paddr[5:2] == 4'(i))
                         ? pwdata[15:0] : areg_ff[i];
  end

  always_comb
  begin
    nxt_pready  = setup;
    nxt_pslverr = setup && bad;
    nxt_prdata  = prdata_ff;
    nxt_ctrl_en = ctrl_en_ff;
    if (setup)
    begin
      if (bad)
        nxt_prdata = 32'h0000_0000;
      else if (paddr == `CFG_CTRL_OFF)
        nxt_prdata = {31'h0, ctrl_en_ff};
      else if (paddr == `CFG_STAT_OFF)
        nxt_prdata = {done_ff, 15'h0000, state_ff == S_RUN};
      else
        nxt_prdata = {16'h0000, areg_ff[paddr[5:2]]};
    end
    if (wr_fire && paddr == `CFG_CTRL_OFF)
      nxt_ctrl_en = pwdata[0];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      ctrl_en_ff <= `CFG_CTRL_RST;
      for (int i = 0; i < `CFG_AREG_NUM; i++)
        areg_ff[i] <= `CFG_AREG_RST;
    end
    else
    begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      ctrl_en_ff <= nxt_ctrl_en;
      for (int i = 0; i < `CFG_AREG_NUM; i++)
        areg_ff[i] <= nxt_areg[i];
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign req_ready = ready_ff;
  assign elem      = out_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_PIPE_DEPTH: assert property (
    s0_ff.valid |-> ##2 (out_ff.valid && out_ff.ch == $past(s0_ff.ch, 2)))
    else $error("element did not emerge two cycles after address");
  AST_QUAD_ROW_ALIGN: assert property (
    (state_ff == S_RUN && req_ff.quad)
    |=> (((addr_ff - $past(col)) & 16'h000F) == 16'h0000))
    else $error("quad row origin not on 16-byte boundary");
  AST_ELEM_NO_MASK: assert property (
    (out_ff.valid && !$past(s1_ff.quad)) |-> out_ff.lane_en)
    else $error("element mode masked a channel");
  AST_QUAD_MASK: assert property (
    (state_ff == S_RUN && req_ff.quad && !req_ff.write_mask[ch_ff[1:0]])
    |-> ##2 (s1_ff.valid && !s1_ff.lane_en))
    else $error("quad write mask not applied");
  AST_ELEM_PTR: assert property (
    (state_ff == S_RUN && form_ff == region_addr_pkg::M_ELEM &&
     !req_ff.quad) |=> (addr_ff == $past(elem_ptr)))
    else $error("element address not taken from its address register");
  AST_REPLICATE: assert property (
    (state_ff == S_RUN && x_ff != 6'h00 && !req_ff.quad &&
     req_ff.element_step == 6'h00) |=> (addr_ff == $past(addr_ff)))
    else $error("zero element step did not replicate");
  AST_BYTE_PROMOTE: assert property (
    (accept && req.first_source_type inside {region_addr_pkg::T_UB,
     region_addr_pkg::T_B} && req.second_source_type inside
     {region_addr_pkg::T_UB, region_addr_pkg::T_B, region_addr_pkg::T_UW,
      region_addr_pkg::T_W}) |=> (exec_ff == region_addr_pkg::X_W))
    else $error("byte sources not promoted to word");
  AST_WIDEST_INT: assert property (
    (accept && req.second_source_type == region_addr_pkg::T_UD &&
     req.first_source_type inside {region_addr_pkg::T_B,
     region_addr_pkg::T_W}) |=> (exec_ff == region_addr_pkg::X_D))
    else $error("mixed integer widths not widened");
  AST_LAST_CHANNEL: assert property (
    (s0_ff.valid && s0_ff.last) |=> !s0_ff.valid)
    else $error("channel addressed after the last one");
  AST_APB_READY: assert property (
    (psel && !penable) |=> (pready && $past(bad) == pslverr))
    else $error("apb access phase not answered next cycle");
endmodule : region_operand_addressing

// File: region_issuer_model.sv
// Decoder stand-in that hands region requests to the addressing block
`timescale 1ns/1ps
module region_issuer_model (
  input  wire logic                    clock,
  input  wire logic                    req_ready,
  output region_addr_pkg::region_req_t req
);
  initial req = '0;

  // Holds the request until taken; gives up after a bounded wait
  task automatic issue(input region_addr_pkg::region_req_t r,
                       output bit ok);
    region_addr_pkg::region_req_t idle;
    ok = 1'b0;
    // Sources stay one class, destination in one register
    @(posedge clock);
    req <= r;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clock);
      ok = req_ready;
    end
    // Released fields must not keep looking valid
    idle = region_addr_pkg::region_req_t'(~r);
    idle.valid = 1'b0;
    req <= idle;
  endtask : issue
endmodule : region_issuer_model

// File: region_operand_addressing_tb.sv
// Self-checking bench for operand region addressing
`timescale 1ns/1ps
module region_operand_addressing_tb;
  logic                         clock;
  logic                         rst_n;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [11:0]                  paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         req_ready;
  region_addr_pkg::region_req_t req;
  region_addr_pkg::wb_req_t     wb;
  region_addr_pkg::elem_out_t   elem;
  int                           errors = 0;
  int                           samples_checked = 0;
  int                           cycles = 0;
  int                           pulses = 0;
  logic [15:0]                  areg [16];
  logic [31:0]                  rd;
  logic                         er;
  bit                           ok;

  region_operand_addressing #(.REG_IDX_W(4)) region_operand_addressing_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req(req), .req_ready(req_ready),
    .wb(wb), .elem(elem));
  region_issuer_model region_issuer_model_inst (
    .clock(clock), .req_ready(req_ready), .req(req));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pulse tally also catches refused requests that leak through
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (elem.valid === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 6000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] pat(input int a);
    return 8'(a) ^ 8'(a >> 4) ^ 8'h5A;
  endfunction : pat

  function automatic region_addr_pkg::region_req_t mk(input logic q, ind,
    input int ri, sub, rs, w, hs, input region_addr_pkg::src_type_t t0, t1,
    input int cc, as);
    mk = '0;
    mk.valid = 1'b1;
    mk.quad = q;
    mk.indirect = ind;
    mk.register_index = 11'(ri);
    mk.subregister_offset = 5'(sub);
    mk.row_step = 6'(rs);
    mk.width = 6'(w);
    mk.element_step = 6'(hs);
    mk.first_source_type = t0;
    mk.second_source_type = t1;
    mk.channel_count = 6'(cc);
    mk.areg_start = 4'(as);
    mk.swizzle = 8'h1B;
    mk.write_mask = 4'h5;
  endfunction : mk

  function automatic logic [63:0] expv(
    input region_addr_pkg::region_req_t r, input int c);
    int es, w, y, a, b;
    logic [63:0] v;
    case (r.first_source_type)
      region_addr_pkg::T_UB, region_addr_pkg::T_B: es = 1;
      region_addr_pkg::T_UW, region_addr_pkg::T_W: es = 2;
      region_addr_pkg::T_DF: es = 8;
      default: es = 4;
    endcase
    w = r.quad ? 4 : int'(r.width);
    y = c / w;
    if (!r.indirect)
      b = r.register_index * 32 + r.subregister_offset * es;
    else if (r.row_step != 6'h0F)
      b = areg[r.areg_start];
    else
      b = areg[(r.areg_start + y) % 16];
    if (!r.indirect || r.row_step != 6'h0F)
      b += y * r.row_step * es;
    if (r.quad)
      a = (b & ~15) + r.swizzle[2*(c%4)+:2] * es;
    else
      a = b + (c % w) * r.element_step * es;
    v = '0;
    for (int i = 0; i < es; i++)
      v[8*i+:8] = pat(a + i);
    if (r.first_source_type inside {region_addr_pkg::T_B,
        region_addr_pkg::T_W, region_addr_pkg::T_D})
      for (int i = es * 8; i < 64; i++)
        v[i] = v[es*8-1];
    return v;
  endfunction : expv

  task automatic run(input region_addr_pkg::region_req_t r,
                     input region_addr_pkg::exec_type_t x, input string tag);
    int c;
    c = 0;
    region_issuer_model_inst.issue(r, ok);
    chk(64'(ok), 64'h1, "request taken");
    for (int i = 0; i < 60 && c < r.channel_count; i++)
    begin
      @(posedge clock);
      if (elem.valid === 1'b1)
      begin
        chk(64'(elem.ch), 64'(c), "channel");
        chk(64'(elem.exec), 64'(x), "exec type");
        chk(64'(elem.lane_en), 64'(!r.quad || r.write_mask[c%4]),
            "lane");
        chk(64'(elem.last), 64'(c == r.channel_count - 1), "last");
        chk(elem.value, expv(r, c), "value");
        c++;
      end
    end
    chk(64'(c), 64'(r.channel_count), "pulse count");
    $display("test %s done", tag);
  endtask : run

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    wb = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(64'(rd), 64'h0, "ctrl reset");
    chk(64'(req_ready), 64'h0, "ready in reset state");
    apb(1'b0, 12'h100, 32'h0);
    chk(64'({er, rd}), 64'h1_0000_0000, "unmapped read");
    apb(1'b1, 12'h002, 32'h1);
    chk(64'(er), 64'h1, "misaligned write");
    for (int i = 0; i < 16; i++)
    begin
      areg[i] = i < 8 ? 16'(256 + 36 * i) : i == 12 ? 16'h00A8 :
                i == 14 ? 16'h00E4 : i == 15 ? 16'h012C : 16'h0000;
      apb(1'b1, 12'(12'h040 + 4 * i), {16'hA5A5, areg[i]});
    end
    apb(1'b0, 12'h070, 32'h0);
    chk(64'(rd), 64'h00A8, "address register readback");
    apb(1'b0, 12'h072, 32'h0);
    chk(64'({er, rd}), 64'h1_0000_0000, "misaligned read");
    for (int r = 0; r < 16; r++)
    begin
      @(posedge clock);
      wb.valid <= 1'b1;
      wb.index <= 11'(r);
      wb.byte_en <= 32'hFFFF_FFFF;
      for (int k = 0; k < 32; k++)
        wb.data[8*k+:8] <= pat(r * 32 + k);
    end
    @(posedge clock);
    wb.valid <= 1'b0;
    // Disabled block must leave the request untaken
    region_issuer_model_inst.issue(mk(0, 0, 1, 1, 16, 8, 2,
      region_addr_pkg::T_W, region_addr_pkg::T_D, 16, 0), ok);
    chk(64'(ok), 64'h0, "request while disabled");
    $display("test refuse done");
    apb(1'b1, 12'h000, 32'h1);
    run(mk(0, 0, 1, 1, 16, 8, 2, region_addr_pkg::T_W,
      region_addr_pkg::T_UD, 16, 0), region_addr_pkg::X_D,
      "direct");
    run(mk(0, 0, 3, 14, 1, 8, 0, region_addr_pkg::T_UB,
      region_addr_pkg::T_UB, 16, 0), region_addr_pkg::X_W,
      "replicate");
    run(mk(0, 1, 0, 0, 2, 2, 1, region_addr_pkg::T_DF,
      region_addr_pkg::T_DF, 4, 12), region_addr_pkg::X_DF,
      "origin");
    run(mk(0, 1, 0, 0, 15, 4, 1, region_addr_pkg::T_F,
      region_addr_pkg::T_VF, 8, 14), region_addr_pkg::X_F,
      "row");
    run(mk(0, 1, 0, 0, 15, 1, 0, region_addr_pkg::T_UD,
      region_addr_pkg::T_UW, 8, 0), region_addr_pkg::X_D,
      "element");
    run(mk(1, 0, 4, 0, 4, 4, 1, region_addr_pkg::T_F,
      region_addr_pkg::T_F, 8, 0), region_addr_pkg::X_F,
      "quad");
    repeat (8) @(posedge clock);
    apb(1'b0, 12'h004, 32'h0);
    chk(64'({rd[31:16], rd[0]}), 64'h0C, "status");
    chk(64'(pulses), 64'd60, "total pulses");
    close_out();
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
endmodule : region_operand_addressing_tb
